// ==== core/smp_pkg.sv ====
/*
  smp_pkg: shared constants and types for the personalization block.
  assumes one 125 MHz clock; all other files qualify names with smp_pkg::.
*/
package smp_pkg;

  // command bytes
  localparam logic [7:0] CLA_STD      = 8'h00;
  localparam logic [7:0] INS_WR_USER  = 8'hb0;
  localparam logic [7:0] INS_SYS_WR   = 8'hb4;
  localparam logic [7:0] INS_SYS_RD   = 8'hb6;
  localparam logic [7:0] INS_VERIFY   = 8'hba;
  localparam logic [7:0] P1_CFG       = 8'h00;
  localparam logic [7:0] P1_FUSE      = 8'h01;
  localparam logic [7:0] P1_ZONE      = 8'h03;
  localparam logic [7:0] PW_SECURE    = 8'h07;
  localparam logic [7:0] PW_LEN       = 8'h03;

  // status words
  localparam logic [7:0] SW_OK_HI     = 8'h90;
  localparam logic [7:0] SW_BAD_HI    = 8'h69;
  localparam logic [7:0] SW_LO        = 8'h00;

  // fuse byte layout, zero means blown; sec arrives already blown from the factory
  localparam int         FUSE_FAB_BIT = 0;
  localparam int         FUSE_CMA_BIT = 1;
  localparam int         FUSE_PER_BIT = 2;
  localparam int         FUSE_SEC_BIT = 3;
  localparam logic [7:0] FUSE_ID_FAB  = 8'h06;
  localparam logic [7:0] FUSE_ID_CMA  = 8'h04;
  localparam logic [7:0] FUSE_ID_PER  = 8'h00;
  localparam logic [3:0] FUSE_RESET   = 4'h7;

  // configuration area
  localparam logic [7:0] CFG_SECURE_ADDR = 8'he9;
  localparam logic [7:0] CFG_AR_FIRST    = 8'h20;
  localparam logic [7:0] CFG_AR_LAST     = 8'h2f;
  localparam logic [7:0] CFG_RESET       = 8'hff;
  localparam logic [3:0] ATTEMPT_RESET   = 4'h0;
  localparam int         USER_BYTES      = 256;

  // nonvolatile write time
  localparam int CLK_HZ      = 125_000_000;
  localparam int T_WR_MS     = 5;
  localparam int T_WR_CYCLES = (CLK_HZ / 1000) * T_WR_MS;

  typedef enum {
    ST_CLA, ST_INS, ST_P1, ST_P2, ST_P3, ST_DATA, ST_RDATA, ST_NVW, ST_SW1, ST_SW2
  } smp_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } smp_byte_type;

endpackage : smp_pkg

// ==== core/smp_core.sv ====
/*
  smp_core: character command engine for one-time personalization of a
  secure memory: user-zone writes, secure-code unlock, configuration
  writes and reads, fuse blowing and fuse readback.
  assumes received characters arrive as one-cycle strobes from a link
  framer synchronous to i_clk_sys, and that answers are taken when the
  framer raises i_tx_ready.
*/
// Function
// - Before any configuration is written every user zone is freely readable and writable; the core has no user-zone read, only writes.
// - Configuration writes are refused until the secure code (write password 7) is verified.
// - Once unlocked, a configuration read of address e9 returns the stored secure code.
// - Written access registers, keys and passwords govern access from the next command on.
// - With all three fuses blown the fuse-byte read shows zero in those fuse bits.
// - A user-zone write is 00 b0, a two-byte address, a length, then that many data bytes.
// - Secure code presentation is 00 ba 07 with length 03 and three password bytes.
// - A configuration write is 00 b4 00, address, count, then the data bytes.
// - Each nonvolatile write completes within 5 ms of the end of its write sequence.
// - Fuses only go from one to zero and only after the secure code has been presented; on reset the core reloads FUSE_RESET, unblowing fab, cma and per.
// - The fuse byte holds the fuse states in bits 0 to 3, zero meaning blown, bits 4 to 7 reserved.
// - A good password clears its attempt counter, records the right and answers 90 00.
`timescale 1ns/100ps
module smp_core #(
  parameter int T_WR_CYCLES = smp_pkg::T_WR_CYCLES
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  // received characters
  input  wire smp_pkg::smp_byte_type i_rx,
  // answer characters
  output smp_pkg::smp_byte_type      o_tx,
  input  wire logic                 i_tx_ready,
  // state
  output logic                      o_busy,
  output logic                      o_cfg_unlocked,
  output logic [3:0]                o_fuses
);

  logic [7:0] user_mem [smp_pkg::USER_BYTES];
  logic [7:0] cfg_mem  [smp_pkg::USER_BYTES];

  smp_pkg::smp_state_type state_reg, state_next;
  logic [7:0]  ins_reg, ins_next;
  logic [7:0]  p1_reg, p1_next;
  logic [7:0]  addr_reg, addr_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  sw1_reg, sw1_next;
  logic        unlock_reg, unlock_next;
  logic [3:0]  fuse_reg, fuse_next;
  logic [3:0]  tries_reg, tries_next;
  logic [23:0] pw_reg, pw_next;
  logic [31:0] tmr_reg, tmr_next;
  logic        nv_pend_reg, nv_pend_next;
  logic [7:0]  txd_reg, txd_next;
  logic        txv_reg, txv_next;
  logic        user_we, cfg_we;
  logic [7:0]  cfg_rd;
  logic [23:0] secure_code;
  logic        user_wr_ok;

  assign secure_code = {cfg_mem[smp_pkg::CFG_SECURE_ADDR + 8'h02],
                        cfg_mem[smp_pkg::CFG_SECURE_ADDR + 8'h01],
                        cfg_mem[smp_pkg::CFG_SECURE_ADDR]};

  // unwritten access registers read ff, which grants free access
  // and a written register takes effect on the next command
  always_comb begin
    user_wr_ok = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (smp_pkg::CFG_AR_FIRST + 8'(i) <= smp_pkg::CFG_AR_LAST &&
          cfg_mem[smp_pkg::CFG_AR_FIRST + 8'(i)] != smp_pkg::CFG_RESET)
        user_wr_ok = user_wr_ok & unlock_reg;
    end
  end

  // locked config reads of address e9, first byte of the secure code, show the fuse byte instead
  always_comb begin
    if (p1_reg == smp_pkg::P1_FUSE) begin
      cfg_rd = {4'h0, fuse_reg};
    end else if (unlock_reg || addr_reg != smp_pkg::CFG_SECURE_ADDR) begin
      cfg_rd = cfg_mem[addr_reg];
    end else begin
      cfg_rd = {4'h0, fuse_reg};
    end
  end

  always_comb begin
    state_next   = state_reg;
    ins_next     = ins_reg;
    p1_next      = p1_reg;
    addr_next    = addr_reg;
    cnt_next     = cnt_reg;
    sw1_next     = sw1_reg;
    unlock_next  = unlock_reg;
    fuse_next    = fuse_reg;
    tries_next   = tries_reg;
    pw_next      = pw_reg;
    tmr_next     = tmr_reg;
    nv_pend_next = nv_pend_reg;
    txd_next     = txd_reg;
    txv_next     = txv_reg;
    user_we      = 1'b0;
    cfg_we       = 1'b0;
    if (txv_reg && i_tx_ready) begin
      txv_next = 1'b0;
    end
    case (state_reg)
      smp_pkg::ST_CLA: begin
        if (i_rx.valid && i_rx.data == smp_pkg::CLA_STD) begin
          state_next = smp_pkg::ST_INS;
        end
      end
      smp_pkg::ST_INS: begin
        if (i_rx.valid) begin
          ins_next   = i_rx.data;
          state_next = smp_pkg::ST_P1;
        end
      end
      smp_pkg::ST_P1: begin
        if (i_rx.valid) begin
          p1_next    = i_rx.data;
          state_next = smp_pkg::ST_P2;
        end
      end
      smp_pkg::ST_P2: begin
        if (i_rx.valid) begin
          addr_next  = i_rx.data;
          state_next = smp_pkg::ST_P3;
        end
      end
      smp_pkg::ST_P3: begin
        if (i_rx.valid) begin
          cnt_next     = i_rx.data;
          sw1_next     = smp_pkg::SW_OK_HI;
          nv_pend_next = 1'b0;
          state_next   = smp_pkg::ST_DATA;
          if (ins_reg == smp_pkg::INS_SYS_RD) begin
            state_next = smp_pkg::ST_RDATA;
          end else if (ins_reg == smp_pkg::INS_SYS_WR && p1_reg == smp_pkg::P1_CFG &&
                       !unlock_reg) begin
            sw1_next = smp_pkg::SW_BAD_HI;
          end else if (ins_reg == smp_pkg::INS_SYS_WR && p1_reg == smp_pkg::P1_FUSE) begin
            state_next = smp_pkg::ST_NVW;
            tmr_next   = 32'(T_WR_CYCLES);
            if (!unlock_reg) begin
              sw1_next = smp_pkg::SW_BAD_HI;
            end else if (addr_reg == smp_pkg::FUSE_ID_FAB) begin
              fuse_next[smp_pkg::FUSE_FAB_BIT] = 1'b0;
            end else if (addr_reg == smp_pkg::FUSE_ID_CMA &&
                         !fuse_reg[smp_pkg::FUSE_FAB_BIT]) begin
              fuse_next[smp_pkg::FUSE_CMA_BIT] = 1'b0;
            end else if (addr_reg == smp_pkg::FUSE_ID_PER &&
                         !fuse_reg[smp_pkg::FUSE_CMA_BIT]) begin
              fuse_next[smp_pkg::FUSE_PER_BIT] = 1'b0;
            end else begin
              sw1_next = smp_pkg::SW_BAD_HI;
            end
          end else if (ins_reg == smp_pkg::INS_VERIFY &&
                       (p1_reg != smp_pkg::PW_SECURE || i_rx.data != smp_pkg::PW_LEN)) begin
            sw1_next = smp_pkg::SW_BAD_HI;
          end else if (ins_reg == smp_pkg::INS_WR_USER && !user_wr_ok) begin
            sw1_next = smp_pkg::SW_BAD_HI;
          end
          if (state_next == smp_pkg::ST_DATA && i_rx.data == 8'h00) begin
            state_next = smp_pkg::ST_SW1;
          end
        end
      end
      smp_pkg::ST_DATA: begin
        if (i_rx.valid) begin
          if (ins_reg == smp_pkg::INS_WR_USER && sw1_reg == smp_pkg::SW_OK_HI) begin
            user_we      = 1'b1;
            nv_pend_next = 1'b1;
          end else if (ins_reg == smp_pkg::INS_SYS_WR && p1_reg == smp_pkg::P1_CFG &&
                       sw1_reg == smp_pkg::SW_OK_HI) begin
            cfg_we       = 1'b1;
            nv_pend_next = 1'b1;
          end else if (ins_reg == smp_pkg::INS_VERIFY) begin
            pw_next = {i_rx.data, pw_reg[23:8]};
          end
          addr_next = addr_reg + 8'h01;
          cnt_next  = cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            state_next = smp_pkg::ST_SW1;
            tmr_next   = 32'(T_WR_CYCLES);
            if (ins_reg == smp_pkg::INS_VERIFY && sw1_reg == smp_pkg::SW_OK_HI) begin
              // attempt counted only when the compare fails
              if ({i_rx.data, pw_reg[23:8]} == secure_code) begin
                unlock_next = 1'b1;
                tries_next  = smp_pkg::ATTEMPT_RESET;
              end else begin
                tries_next = tries_reg + 4'h1;
                sw1_next   = smp_pkg::SW_BAD_HI;
              end
            end else if (nv_pend_reg || user_we || cfg_we) begin
              state_next = smp_pkg::ST_NVW;
            end
          end
        end
      end
      smp_pkg::ST_RDATA: begin
        if (!txv_reg || i_tx_ready) begin
          txd_next  = (p1_reg == smp_pkg::P1_CFG || p1_reg == smp_pkg::P1_FUSE) ?
                      cfg_rd : 8'h00;
          txv_next  = 1'b1;
          addr_next = addr_reg + 8'h01;
          cnt_next  = cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            state_next = smp_pkg::ST_SW1;
          end
        end
      end
      smp_pkg::ST_NVW: begin
        // internal write time, bounded by the counter
        if (tmr_reg <= 32'd1) begin
          state_next = smp_pkg::ST_SW1;
        end else begin
          tmr_next = tmr_reg - 32'd1;
        end
      end
      smp_pkg::ST_SW1: begin
        if (!txv_reg || i_tx_ready) begin
          txd_next   = sw1_reg;
          txv_next   = 1'b1;
          state_next = smp_pkg::ST_SW2;
        end
      end
      smp_pkg::ST_SW2: begin
        if (!txv_reg || i_tx_ready) begin
          txd_next   = smp_pkg::SW_LO;
          txv_next   = 1'b1;
          state_next = smp_pkg::ST_CLA;
        end
      end
      default: state_next = smp_pkg::ST_CLA;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg   <= smp_pkg::ST_CLA;
      ins_reg     <= 8'h00;
      p1_reg      <= 8'h00;
      addr_reg    <= 8'h00;
      cnt_reg     <= 8'h00;
      sw1_reg     <= 8'h00;
      unlock_reg  <= 1'b0;
      fuse_reg    <= smp_pkg::FUSE_RESET;
      tries_reg   <= smp_pkg::ATTEMPT_RESET;
      pw_reg      <= 24'h000000;
      tmr_reg     <= 32'h00000000;
      nv_pend_reg <= 1'b0;
      txd_reg     <= 8'h00;
      txv_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ins_reg     <= ins_next;
      p1_reg      <= p1_next;
      addr_reg    <= addr_next;
      cnt_reg     <= cnt_next;
      sw1_reg     <= sw1_next;
      unlock_reg  <= unlock_next;
      fuse_reg    <= fuse_next;
      tries_reg   <= tries_next;
      pw_reg      <= pw_next;
      tmr_reg     <= tmr_next;
      nv_pend_reg <= nv_pend_next;
      txd_reg     <= txd_next;
      txv_reg     <= txv_next;
    end
  end

  // storage has no reset; fresh parts read ff everywhere
  initial begin
    for (int i = 0; i < smp_pkg::USER_BYTES; i++) begin
      user_mem[i] = smp_pkg::CFG_RESET;
      cfg_mem[i]  = smp_pkg::CFG_RESET;
    end
  end

  always @(posedge i_clk_sys) begin // shares the arrays with the initial fill
    if (user_we) begin
      user_mem[addr_reg] <= i_rx.data;
    end
    if (cfg_we) begin
      cfg_mem[addr_reg] <= i_rx.data;
    end
  end

  assign o_tx.valid     = txv_reg;
  assign o_tx.data      = txd_reg;
  assign o_busy         = (state_reg == smp_pkg::ST_NVW);
  assign o_cfg_unlocked = unlock_reg;
  assign o_fuses        = fuse_reg;

endmodule : smp_core

// ==== dv/smp_core_props.sv ====
/*
  smp_core_props: port-level checks on the personalization engine.
  assumes one clock domain; bound to every smp_core at the foot of this file.
*/
`timescale 1ns/100ps
module smp_core_props #(
  parameter int T_WR_CYCLES = smp_pkg::T_WR_CYCLES
) (
  // design ports
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire smp_pkg::smp_byte_type i_rx,
  input wire smp_pkg::smp_byte_type o_tx,
  input wire logic                  i_tx_ready,
  input wire logic                  o_busy,
  input wire logic                  o_cfg_unlocked,
  input wire logic [3:0]            o_fuses
);
  logic [19:0] busy_cnt_reg;
  logic [19:0] busy_cnt_next;

  always_comb begin
    busy_cnt_next = o_busy ? busy_cnt_reg + 20'h1 : 20'h0;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt_reg <= 20'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_ok_now;
    o_tx.valid && o_tx.data == smp_pkg::SW_OK_HI;
  endsequence
  // status high byte is loaded one edge after the unlock register
  sequence s_ok_next;
    ##1 s_ok_now;
  endsequence

  property p_tx_stands;
    o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data);
  endproperty
  property p_fuse_one_way;
    1'b1 |=> (o_fuses & ~$past(o_fuses)) == 4'h0;
  endproperty
  property p_fuse_unlocked;
    $changed(o_fuses) && $past(i_arst_n) |-> o_cfg_unlocked;
  endproperty
  property p_cma_order;
    !o_fuses[smp_pkg::FUSE_CMA_BIT] |-> !o_fuses[smp_pkg::FUSE_FAB_BIT];
  endproperty
  property p_per_order;
    !o_fuses[smp_pkg::FUSE_PER_BIT] |-> !o_fuses[smp_pkg::FUSE_CMA_BIT];
  endproperty
  property p_busy_bound;
    o_busy |-> busy_cnt_reg <= 20'(T_WR_CYCLES);
  endproperty
  property p_busy_quiet;
    o_busy |-> !o_tx.valid;
  endproperty
  property p_unlock_ok;
    $rose(o_cfg_unlocked) |-> s_ok_next;
  endproperty
  property p_sec_kept;
    o_fuses[smp_pkg::FUSE_SEC_BIT] == 1'b0;
  endproperty

  a_tx_stands: assert property (p_tx_stands)
    else $error("answer byte changed before it was taken");
  a_fuse_one_way: assert property (p_fuse_one_way)
    else $error("fuse bit went from zero to one");
  a_fuse_unlocked: assert property (p_fuse_unlocked)
    else $error("fuse changed while locked");
  a_cma_order: assert property (p_cma_order)
    else $error("config access fuse blown before fabrication fuse");
  a_per_order: assert property (p_per_order)
    else $error("personalization fuse blown before config access fuse");
  a_busy_bound: assert property (p_busy_bound)
    else $error("nonvolatile write ran too long");
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("answer presented during nonvolatile write");
  a_unlock_ok: assert property (p_unlock_ok)
    else $error("unlock without success status");
  a_sec_kept: assert property (p_sec_kept)
    else $error("reserved security fuse changed");
endmodule : smp_core_props

bind smp_core smp_core_props #(.T_WR_CYCLES(T_WR_CYCLES)) u_props (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_rx(i_rx), .o_tx(o_tx),
  .i_tx_ready(i_tx_ready), .o_busy(o_busy), .o_cfg_unlocked(o_cfg_unlocked),
  .o_fuses(o_fuses));

// ==== dv/smp_host_model.sv ====
/*
  smp_host_model: host side of the answer path, takes answer bytes.
  assumes the bench reads rx_q by hierarchy and clears it per command.
*/
`timescale 1ns/100ps
module smp_host_model (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  // answer path
  input  wire smp_pkg::smp_byte_type i_tx,
  input  wire logic                  i_slow,
  output logic                       o_tx_ready
);
  logic [1:0] pace_reg;
  logic [7:0] rx_q [$];

  // slow mode stalls two cycles in three to exercise held answers
  assign o_tx_ready = !i_slow || pace_reg == 2'h2;

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= (pace_reg == 2'h2) ? 2'h0 : pace_reg + 2'h1;
      if (i_tx.valid && o_tx_ready)
        rx_q.push_back(i_tx.data);
    end
  end
endmodule : smp_host_model

// ==== dv/smp_core_tb_top.sv ====
/*
  smp_core_tb_top: table-driven bench for the personalization engine.
  assumes the host model takes answers and the checker binds itself.
*/
`timescale 1ns/100ps
module smp_core_tb_top;
  typedef struct packed {
    logic [3:0]  nc;
    logic [63:0] cmd;
    logic [2:0]  ne;
    logic [39:0] ex;
  } smp_row_type;

  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  smp_pkg::smp_byte_type rx = '0;
  smp_pkg::smp_byte_type tx;
  logic                  ready;
  logic                  slow = 1'b0;
  logic                  busy;
  logic                  unlocked;
  logic [3:0]            fuses;
  int                    miscompares = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  int                    busy_seen = 0;
  localparam int         WR_CYCLES = 10;
  smp_row_type           rows [13] = '{
    '{4'h7, 64'h00b0000002aa55, 3'h2, 40'h9000},
    '{4'h6, 64'h00b40020017f, 3'h2, 40'h6900},
    '{4'h5, 64'h00b4010600, 3'h2, 40'h6900},
    '{4'h8, 64'h00ba060003ffffff, 3'h2, 40'h6900},
    '{4'h8, 64'h00ba070003ffffff, 3'h2, 40'h9000},
    '{4'h5, 64'h00b600e903, 3'h5, 40'hffffff9000},
    '{4'h6, 64'h00b40020017f, 3'h2, 40'h9000},
    '{4'h5, 64'h00b6002001, 3'h3, 40'h7f9000},
    '{4'h5, 64'h00b4010000, 3'h2, 40'h6900},
    '{4'h5, 64'h00b4010600, 3'h2, 40'h9000},
    '{4'h5, 64'h00b4010400, 3'h2, 40'h9000},
    '{4'h5, 64'h00b4010000, 3'h2, 40'h9000},
    '{4'h5, 64'h00b6010001, 3'h3, 40'h009000}};

  smp_core #(.T_WR_CYCLES(WR_CYCLES)) uut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_rx(rx),
    .o_tx(tx), .i_tx_ready(ready), .o_busy(busy), .o_cfg_unlocked(unlocked),
    .o_fuses(fuses));
  smp_host_model host (.i_clk_sys(clk), .i_arst_n(rst_n), .i_tx(tx), .i_slow(slow),
    .o_tx_ready(ready));

  always #4 clk = ~clk;

  task automatic test_done();
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic run_row(input smp_row_type r);
    int i;
    host.rx_q.delete();
    busy_seen = 0;
    for (i = 0; i < r.nc; i++) begin
      @(posedge clk);
      rx <= '{1'b1, r.cmd[8*(r.nc-1-i) +: 8]};
    end
    @(posedge clk);
    rx <= '0;
    i = 0;
    // next command only once the whole status word is in
    while (host.rx_q.size() < r.ne && i < 500) begin
      @(posedge clk);
      i++;
      if (busy)
        busy_seen++;
    end
    // a missing answer is a mismatch, not a silent skip
    if (i >= 500)
      miscompares++;
    for (i = 0; i < r.ne; i++)
      chk(host.rx_q[i], r.ex[8*(r.ne-1-i) +: 8]);
  endtask : run_row

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({4'h0, fuses}, {4'h0, smp_pkg::FUSE_RESET});
    chk({7'h00, unlocked}, 8'h00);
    for (int k = 0; k < 13; k++) begin
      slow <= k[0];
      run_row(rows[k]);
      if (k == 11)
        chk(8'(busy_seen), 8'(WR_CYCLES));
    end
    chk({4'h0, fuses}, 8'h00);
    // mid-run reset: unlock is volatile, access register survives
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({7'h00, unlocked}, 8'h00);
    run_row('{4'h7, 64'h00b0000002aa55, 3'h2, 40'h6900});
    chk(8'(busy_seen), 8'h00);
    test_done();
  end
endmodule : smp_core_tb_top
